// *** rtl/sdram_pin_pkg.sv ***
// Shared constants and types for the synchronous DRAM pin interface.
package sdram_pin_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_BITS = 2;
  localparam int ADDR_PINS = 12;
  localparam int ROW_BITS_DEF = 12;
  localparam int COL_BITS_DEF = 9;
  localparam int DATA_BITS = 16;
  localparam int PRECHARGE_BIT = 10;
  localparam int BURST_LEN_DEF = 4;
  localparam int READ_LATENCY_DEF = 2;
  localparam int WBUF_DEPTH = 16;
  localparam logic [NUM_BANKS-1:0] BANK_OPEN_RST = 4'h0;
  localparam logic [DATA_BITS-1:0] DATA_RST = 16'h0000;

  // Gray coded along normal <-> power-down; self-refresh is one bit from power-down
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_SELF_REFRESH = 2'h3
  } pwr_state_t;
endpackage

// *** rtl/sdram_pin_iface.sv ***
// Pin-level command decoder, bank state, data path and write buffer.
`timescale 1ns/1ps
`default_nettype none

module wbuf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty; depth must be a power of two
  assign full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = buf_q[rd_q[PW-1:0]];

  // Write pointer and storage
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
    end else if (in_valid && !full) begin
      buf_q[wr_q[PW-1:0]] <= in_data;
      wr_q <= wr_q + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= '0;
    end else if (out_ready && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule

module sdram_pin_iface
  import sdram_pin_pkg::*;
#(
  parameter int ROW_BITS = sdram_pin_pkg::ROW_BITS_DEF,
  parameter int COL_BITS = sdram_pin_pkg::COL_BITS_DEF,
  parameter int BURST_LEN = sdram_pin_pkg::BURST_LEN_DEF,
  parameter int READ_LATENCY = sdram_pin_pkg::READ_LATENCY_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Command pins
  input wire logic CKE,
  input wire logic CHIP_SELECT_N,
  input wire logic ROW_STROBE_N,
  input wire logic COLUMN_STROBE_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic BANK_SEL_0,
  input wire logic BANK_SEL_1,
  input wire logic [sdram_pin_pkg::ADDR_PINS-1:0] ADDR,
  // Data pins and byte masks
  input wire logic LOWER_BYTE_MASK,
  input wire logic UPPER_BYTE_MASK,
  input wire logic [sdram_pin_pkg::DATA_BITS-1:0] DATA_PINS_I,
  output logic [sdram_pin_pkg::DATA_BITS-1:0] DATA_PINS_O,
  output logic [1:0] DATA_PINS_OE,
  // Status
  output logic [sdram_pin_pkg::NUM_BANKS-1:0] BANK_OPEN,
  output logic [1:0] LOW_POWER_STATE,
  output logic WR_BUF_READY
);
  import sdram_pin_pkg::*;

  localparam int IDX_W = BANK_BITS + ROW_BITS + COL_BITS;
  localparam int BL_W = $clog2(BURST_LEN + 1);
  localparam int WB_W = IDX_W + DATA_BITS + 2;
  localparam logic [BL_W-1:0] BEATS_AFTER_FIRST = BL_W'(BURST_LEN - 1);

  // Flat cell index, shared by the write buffer fill and the read port
  function automatic logic [IDX_W-1:0] cell_idx(input logic [BANK_BITS-1:0] b,
                                                input logic [ROW_BITS-1:0] r,
                                                input logic [COL_BITS-1:0] c);
    cell_idx = {b, r, c};
  endfunction

  logic cke_prev_q;
  logic run;
  logic dec_en;
  logic cmd_act, cmd_pre, cmd_rd, cmd_wr, cmd_col, cmd_ref;
  logic [BANK_BITS-1:0] bank;
  logic precharge_flag_a10;
  logic [ROW_BITS-1:0] row_addr_bits;
  logic [COL_BITS-1:0] col_addr_bits;
  logic [NUM_BANKS-1:0] open_q;
  logic [ROW_BITS-1:0] row_q [NUM_BANKS];
  logic [BL_W-1:0] beat_left_q;
  logic [BANK_BITS-1:0] bk_q;
  logic [COL_BITS-1:0] col_q;
  logic wr_q, autopre_q;
  logic beat_now, beat_ok, beat_wr, beat_last, beat_autopre;
  logic [BANK_BITS-1:0] beat_bank;
  logic [COL_BITS-1:0] beat_col;
  logic [DATA_BITS-1:0] mem_q [2**IDX_W];
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [WB_W-1:0] fifo_in_data, fifo_out_data;
  logic [IDX_W-1:0] drain_idx;
  logic [1:0] drain_be;
  logic [DATA_BITS-1:0] drain_data;
  logic rd_v_q [READ_LATENCY-1];
  logic [DATA_BITS-1:0] rd_d_q [READ_LATENCY-1];
  logic rd_out_v_q;
  logic [1:0] mask_p1_q;
  pwr_state_t pwr_q;

  // Clock enable of the previous edge gates this edge, as a stopped clock would
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= CKE;
    end
  end
  assign run = cke_prev_q;

  // Command decode from the strobes, only while selected
  assign dec_en = run && !CHIP_SELECT_N;
  assign cmd_act = dec_en && !ROW_STROBE_N && COLUMN_STROBE_N && WRITE_ENABLE_N;
  assign cmd_pre = dec_en && !ROW_STROBE_N && COLUMN_STROBE_N && !WRITE_ENABLE_N;
  assign cmd_rd = dec_en && ROW_STROBE_N && !COLUMN_STROBE_N && WRITE_ENABLE_N;
  assign cmd_wr = dec_en && ROW_STROBE_N && !COLUMN_STROBE_N && !WRITE_ENABLE_N;
  assign cmd_col = cmd_rd || cmd_wr;
  assign cmd_ref = !CHIP_SELECT_N && !ROW_STROBE_N && !COLUMN_STROBE_N && WRITE_ENABLE_N;
  assign bank = {BANK_SEL_1, BANK_SEL_0};
  assign precharge_flag_a10 = ADDR[PRECHARGE_BIT];
  assign row_addr_bits = ADDR[ROW_BITS-1:0];
  assign col_addr_bits = ADDR[COL_BITS-1:0];

  // Low-power entry picks self-refresh when a refresh accompanies the falling enable
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pwr_q <= PWR_NORMAL;
    end else begin
      case (pwr_q)
        PWR_NORMAL: begin
          if (cke_prev_q && !CKE) begin
            pwr_q <= cmd_ref ? PWR_SELF_REFRESH : PWR_DOWN;
          end
        end
        PWR_DOWN, PWR_SELF_REFRESH: begin
          if (CKE) begin
            pwr_q <= PWR_NORMAL;
          end
        end
        default: pwr_q <= PWR_NORMAL;
      endcase
    end
  end
  assign LOW_POWER_STATE = pwr_q;

  // Burst tracker; beat zero happens on the command edge itself
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      beat_left_q <= '0;
      bk_q <= '0;
      col_q <= '0;
      wr_q <= 1'b0;
      autopre_q <= 1'b0;
    end else if (run) begin
      if (cmd_col) begin
        beat_left_q <= BEATS_AFTER_FIRST;
        bk_q <= bank;
        col_q <= col_addr_bits + 1'b1;
        wr_q <= cmd_wr;
        autopre_q <= precharge_flag_a10;
      end else if (beat_left_q != '0) begin
        beat_left_q <= beat_left_q - 1'b1;
        col_q <= col_q + 1'b1;
      end
    end
  end

  // Current beat; columns count linearly, wrapping at the row's end
  assign beat_now = run && (cmd_col || (beat_left_q != '0));
  assign beat_bank = cmd_col ? bank : bk_q;
  assign beat_col = cmd_col ? col_addr_bits : col_q;
  assign beat_wr = cmd_col ? cmd_wr : wr_q;
  assign beat_ok = beat_now && open_q[beat_bank];
  assign beat_last = cmd_col ? (BURST_LEN == 1) : (beat_left_q == BL_W'(1));
  assign beat_autopre = beat_now && beat_last && (cmd_col ? precharge_flag_a10 : autopre_q);

  // Per-bank open flag and row; a new command outranks the auto-precharge
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      open_q <= BANK_OPEN_RST;
    end else if (run) begin
      if (beat_autopre) begin
        open_q[beat_bank] <= 1'b0;
      end
      if (cmd_act) begin
        open_q[bank] <= 1'b1;
        row_q[bank] <= row_addr_bits;
      end else if (cmd_pre && precharge_flag_a10) begin
        open_q <= BANK_OPEN_RST;
      end else if (cmd_pre) begin
        open_q[bank] <= 1'b0;
      end
    end
  end
  assign BANK_OPEN = open_q;

  // Write beats go to the buffer with the masks of the same edge
  assign fifo_in_valid = beat_ok && beat_wr && !(LOWER_BYTE_MASK && UPPER_BYTE_MASK);
  assign fifo_in_data = {cell_idx(beat_bank, row_q[beat_bank], beat_col), DATA_PINS_I,
                         !UPPER_BYTE_MASK, !LOWER_BYTE_MASK};
  // Single-ported array: a read beat takes the port, so the drain waits
  assign fifo_out_ready = run && !(beat_ok && !beat_wr);

  wbuf_fifo #(
    .WIDTH(WB_W),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .clk(CLK),
    .rst(SYS_RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Buffer space seen by the controller; a write beat into a full buffer is lost
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      WR_BUF_READY <= 1'b0;
    end else begin
      WR_BUF_READY <= fifo_in_ready;
    end
  end

  // Array write from the buffer, byte lanes independent
  assign drain_idx = fifo_out_data[WB_W-1 -: IDX_W];
  assign drain_data = fifo_out_data[DATA_BITS+1:2];
  assign drain_be = fifo_out_data[1:0];
  always_ff @(posedge CLK) begin
    if (fifo_out_valid && fifo_out_ready) begin
      if (drain_be[0]) begin
        mem_q[drain_idx][7:0] <= drain_data[7:0];
      end
      if (drain_be[1]) begin
        mem_q[drain_idx][15:8] <= drain_data[15:8];
      end
    end
  end

  // Read latency pipeline, frozen while the clock is stopped.
  // Reads do not see words still waiting in the buffer.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < READ_LATENCY - 1; i++) begin
        rd_v_q[i] <= 1'b0;
        rd_d_q[i] <= DATA_RST;
      end
      rd_out_v_q <= 1'b0;
      DATA_PINS_O <= DATA_RST;
    end else if (run) begin
      rd_v_q[0] <= beat_ok && !beat_wr;
      rd_d_q[0] <= mem_q[cell_idx(beat_bank, row_q[beat_bank], beat_col)];
      for (int i = 1; i < READ_LATENCY - 1; i++) begin
        rd_v_q[i] <= rd_v_q[i-1];
        rd_d_q[i] <= rd_d_q[i-1];
      end
      rd_out_v_q <= rd_v_q[READ_LATENCY-2];
      DATA_PINS_O <= rd_d_q[READ_LATENCY-2];
    end
  end

  // Masks act as output enables two edges after sampling
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mask_p1_q <= 2'h3;
      DATA_PINS_OE <= 2'h0;
    end else begin
      mask_p1_q <= {UPPER_BYTE_MASK, LOWER_BYTE_MASK};
      DATA_PINS_OE[0] <= rd_v_q[READ_LATENCY-2] && !mask_p1_q[0];
      DATA_PINS_OE[1] <= rd_v_q[READ_LATENCY-2] && !mask_p1_q[1];
    end
  end

  // Checks on the decoder, bank state and data path
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  property p_stop_freezes;
    !run |=> $stable(beat_left_q) && $stable(open_q);
  endproperty
  a_stop_freezes: assert property (p_stop_freezes) else $error("state moved with clock stopped");

  property p_burst_continues;
    (run && CHIP_SELECT_N && beat_left_q != '0) |=> beat_left_q == $past(beat_left_q) - 1'b1;
  endproperty
  a_burst_continues: assert property (p_burst_continues) else $error("burst halted on deselect");

  property p_activate_opens;
    cmd_act |=> open_q[$past(bank)] && row_q[$past(bank)] == $past(row_addr_bits);
  endproperty
  a_activate_opens: assert property (p_activate_opens) else $error("activate did not open row");

  property p_precharge_all;
    (cmd_pre && precharge_flag_a10) |=> open_q == BANK_OPEN_RST;
  endproperty
  a_precharge_all: assert property (p_precharge_all) else $error("precharge all left bank open");

  property p_precharge_one;
    (cmd_pre && !precharge_flag_a10) |=>
      !open_q[$past(bank)] && ((open_q & ~$past(open_q)) == '0);
  endproperty
  a_precharge_one: assert property (p_precharge_one) else $error("single precharge wrong bank");

  property p_auto_precharge;
    (beat_autopre && !cmd_act) |=> !open_q[$past(beat_bank)];
  endproperty
  a_auto_precharge: assert property (p_auto_precharge) else $error("no precharge after burst");

  property p_row_stays_open;
    (beat_now && beat_last && !beat_autopre && open_q[beat_bank] && !cmd_pre)
      |=> open_q[$past(beat_bank)];
  endproperty
  a_row_stays_open: assert property (p_row_stays_open) else $error("row closed without flag");

  property p_read_mask_delay;
    DATA_PINS_OE[0] |-> !$past(LOWER_BYTE_MASK, 2) && $past(rd_v_q[READ_LATENCY-2]);
  endproperty
  a_read_mask_delay: assert property (p_read_mask_delay) else $error("read mask latency wrong");

  property p_write_mask_now;
    (cmd_wr && open_q[bank] && !LOWER_BYTE_MASK && fifo_in_ready)
      |=> u_wbuf.wr_q == $past(u_wbuf.wr_q) + 1'b1;
  endproperty
  a_write_mask_now: assert property (p_write_mask_now) else $error("unmasked write not buffered");
endmodule

`default_nettype wire

// *** bench/sdram_ctl_model.sv ***
// Memory-controller model driving command, address, mask and write-data pins.
`timescale 1ns/1ps
`default_nettype none

module sdram_ctl_model (
  // Clock from the bench
  input wire logic CLK,
  // Command pins
  output logic CKE,
  output logic CHIP_SELECT_N,
  output logic ROW_STROBE_N,
  output logic COLUMN_STROBE_N,
  output logic WRITE_ENABLE_N,
  output logic BANK_SEL_0,
  output logic BANK_SEL_1,
  output logic [sdram_pin_pkg::ADDR_PINS-1:0] ADDR,
  // Masks and write data
  output logic LOWER_BYTE_MASK,
  output logic UPPER_BYTE_MASK,
  output logic [sdram_pin_pkg::DATA_BITS-1:0] DATA_PINS_I
);
  import sdram_pin_pkg::*;

  // Idle bus from time zero: clock enabled, device deselected
  initial begin
    CKE = 1'b1;
    CHIP_SELECT_N = 1'b1;
    {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} = 3'h7;
    {BANK_SEL_1, BANK_SEL_0} = 2'h0;
    ADDR = 12'h000;
    {UPPER_BYTE_MASK, LOWER_BYTE_MASK} = 2'h0;
    DATA_PINS_I = 16'h0000;
  end

  // One bus cycle: pins change after the falling edge and hold over the next rising edge
  task automatic drive(input logic cke, input logic cs_n, input logic [2:0] cmd,
                       input logic [1:0] bank, input logic [11:0] a,
                       input logic [1:0] mask, input logic [15:0] d);
    @(negedge CLK);
    CKE = cke;
    CHIP_SELECT_N = cs_n;
    {ROW_STROBE_N, COLUMN_STROBE_N, WRITE_ENABLE_N} = cmd;
    {BANK_SEL_1, BANK_SEL_0} = bank;
    ADDR = a;
    {UPPER_BYTE_MASK, LOWER_BYTE_MASK} = mask;
    DATA_PINS_I = d;
  endtask

  // Deselected cycle; released lines flip so stale data never passes for a beat
  task automatic idle(input logic [1:0] mask);
    drive(1'b1, 1'b1, 3'h7, 2'h0, ~ADDR, mask, ~DATA_PINS_I);
  endtask
endmodule

`default_nettype wire

// *** bench/sdram_pin_command_interface_tb.sv ***
// Self-checking bench for the DRAM pin command interface.
`timescale 1ns/1ps
`default_nettype none

module sdram_pin_command_interface_tb;
  import sdram_pin_pkg::*;
  localparam logic [2:0] ACT = 3'h3;
  localparam logic [2:0] PRE = 3'h2;
  localparam logic [2:0] RD = 3'h5;
  localparam logic [2:0] WR = 3'h4;
  localparam logic [2:0] NOP = 3'h7;
  localparam logic [2:0] SREF = 3'h1;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cke, cs_n, row_n, col_n, we_n, bank_sel_0, bank_sel_1, lmask, umask, wbr;
  logic [11:0] addr;
  logic [15:0] din, dout, e;
  logic [1:0] oe, lps, b;
  logic [3:0] bank_open;
  logic [2:0] col;
  logic close_after;
  logic [15:0] d [4];
  logic [1:0] rm [4];
  int err_count = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  sdram_ctl_model sdram_ctl_model_inst (.CLK(clk), .CKE(cke), .CHIP_SELECT_N(cs_n),
    .ROW_STROBE_N(row_n), .COLUMN_STROBE_N(col_n), .WRITE_ENABLE_N(we_n),
    .BANK_SEL_0(bank_sel_0), .BANK_SEL_1(bank_sel_1), .ADDR(addr), .LOWER_BYTE_MASK(lmask),
    .UPPER_BYTE_MASK(umask),
    .DATA_PINS_I(din));

  // Small arrays keep the run short; expectations follow these sizes
  sdram_pin_iface #(.ROW_BITS(4), .COL_BITS(3)) sdram_pin_iface_inst (.CLK(clk),
    .SYS_RST(sys_rst), .CKE(cke), .CHIP_SELECT_N(cs_n), .ROW_STROBE_N(row_n),
    .COLUMN_STROBE_N(col_n), .WRITE_ENABLE_N(we_n), .BANK_SEL_0(bank_sel_0),
    .BANK_SEL_1(bank_sel_1),
    .ADDR(addr), .LOWER_BYTE_MASK(lmask), .UPPER_BYTE_MASK(umask), .DATA_PINS_I(din),
    .DATA_PINS_O(dout), .DATA_PINS_OE(oe), .BANK_OPEN(bank_open), .LOW_POWER_STATE(lps),
    .WR_BUF_READY(wbr));

  task automatic chk_data(input logic [15:0] act, input logic [15:0] exp);
    n_checks++;
    if (act !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic chk_stat(input logic [3:0] act, input logic [3:0] exp);
    n_checks++;
    if (act !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic results;
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmd(input logic ck, input logic cs, input logic [2:0] c, input logic [1:0] bk,
                     input logic [11:0] a, input logic [1:0] m, input logic [15:0] w);
    sdram_ctl_model_inst.drive(ck, cs, c, bk, a, m, w);
  endtask

  task automatic idle(input logic [1:0] m);
    sdram_ctl_model_inst.idle(m);
  endtask

  // Byte lanes kept from the old word where the mask is high
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                        input logic [1:0] m);
    return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
  endfunction

  function automatic logic [15:0] lanes(input logic [1:0] m);
    return {{8{m[1]}}, {8{m[0]}}};
  endfunction

  // Column command address with junk in the unused upper bits
  function automatic logic [11:0] caddr(input logic [2:0] c, input logic pf);
    logic [11:0] r;
    r = 12'($urandom);
    return {r[11], pf, r[9:3], c};
  endfunction

  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    results();
  end

  initial begin
    void'($urandom(86));
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk_stat({lps, oe}, 4'h0);
    chk_stat(bank_open, 4'h0);
    sys_rst = 1'b0;
    idle(2'h0);
    chk_stat({3'h0, wbr}, 4'h1);
    // Deselected activate must not open a bank
    cmd(1'b1, 1'b1, ACT, 2'h1, 12'h000, 2'h0, 16'h0000);
    idle(2'h0);
    chk_stat(bank_open, 4'h0);
    for (int it = 0; it < 8; it++) begin
      b = 2'($urandom_range(3, 0));
      col = (it == 0) ? 3'h6 : 3'($urandom_range(7, 0));
      // First two passes pin both burst endings, the rest are drawn
      close_after = (it < 2) ? 1'(it == 0) : 1'($urandom_range(1, 0));
      cmd(1'b1, 1'b0, ACT, b, 12'($urandom), 2'h0, 16'h0000);
      idle(2'h0);
      chk_stat(bank_open, 4'h1 << b);
      // Full burst, then a masked burst over it
      for (int p = 0; p < 2; p++) begin
        for (int j = 0; j < 4; j++) begin
          e = 16'($urandom);
          rm[j] = (p == 0) ? 2'h0 : 2'($urandom_range(3, 0));
          d[j] = (p == 0) ? e : merge(d[j], e, rm[j]);
          cmd(1'b1, j != 0, (j != 0) ? NOP : WR, b, caddr(col, 1'b0), rm[j], e);
        end
        chk_stat({3'h0, wbr}, 4'h1);
        repeat (8) idle(2'h0);
      end
      for (int j = 0; j < 4; j++) rm[j] = 2'($urandom_range(3, 0));
      cmd(1'b1, 1'b0, RD, b, caddr(col, close_after), rm[0], ~din);
      for (int k = 1; k < 7; k++) begin
        idle((k < 4) ? rm[k] : 2'h0);
        if (k >= 2 && k <= 5) begin
          chk_stat({2'h0, oe}, {2'h0, ~rm[k-2]});
          chk_data(dout & lanes(~rm[k-2]), d[k-2] & lanes(~rm[k-2]));
        end else begin
          chk_stat({2'h0, oe}, 4'h0);
        end
      end
      chk_stat(bank_open, close_after ? 4'h0 : 4'h1 << b);
      if (!close_after) begin
        cmd(1'b1, 1'b0, PRE, b, 12'h000, 2'h0, 16'h0000);
        idle(2'h0);
        chk_stat(bank_open, 4'h0);
      end
    end
    // Back-to-back activates on all banks, then single and all-bank precharge
    for (int bb = 0; bb < 4; bb++) cmd(1'b1, 1'b0, ACT, 2'(bb), 12'($urandom), 2'h0, 16'h0);
    idle(2'h0);
    chk_stat(bank_open, 4'hf);
    b = 2'($urandom_range(3, 0));
    cmd(1'b1, 1'b0, PRE, b, 12'h3ff, 2'h0, 16'h0000);
    idle(2'h0);
    chk_stat(bank_open, 4'hf & ~(4'h1 << b));
    cmd(1'b1, 1'b0, PRE, ~b, 12'h400, 2'h0, 16'h0000);
    idle(2'h0);
    chk_stat(bank_open, 4'h0);
    // Power-down: commands while stopped are ignored
    cmd(1'b0, 1'b1, NOP, 2'h0, 12'h000, 2'h0, 16'h0000);
    cmd(1'b0, 1'b0, ACT, 2'h2, 12'h000, 2'h0, 16'h0000);
    chk_stat({2'h0, lps}, 4'h1);
    cmd(1'b1, 1'b1, NOP, 2'h0, 12'h000, 2'h0, 16'h0000);
    chk_stat(bank_open, 4'h0);
    idle(2'h0);
    chk_stat({2'h0, lps}, 4'h0);
    // Self-refresh entry
    cmd(1'b0, 1'b0, SREF, 2'h0, 12'h000, 2'h0, 16'h0000);
    idle(2'h0);
    chk_stat({2'h0, lps}, 4'h3);
    idle(2'h0);
    chk_stat({2'h0, lps}, 4'h0);
    results();
  end
endmodule

`default_nettype wire
